// File: verilog/spcb_pkg.sv
// package: register map, field positions and link constants of the config bank
package spcb_pkg;

    // ------------------------------------------------------------
    // device register map
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 13;
    localparam logic [12:0] REG_SETUP    = 13'h0000;
    localparam logic [12:0] REG_RDSEL    = 13'h0004;
    localparam logic [12:0] REG_PDSYNC   = 13'h0230;
    localparam logic [12:0] REG_RSVD     = 13'h0231;
    localparam logic [12:0] REG_COMMIT   = 13'h0232;
    localparam logic [12:0] REG_CFG_BASE = 13'h0010;

    // ------------------------------------------------------------
    // device fields and reset values
    // ------------------------------------------------------------
    localparam int         SETUP_DIR_BIT   = 7;
    localparam int         SETUP_LSB_BIT   = 6;
    localparam int         SETUP_SRST_BIT  = 5;
    localparam int         SETUP_LONG_BIT  = 4;
    localparam int         SETUP_MSRST_BIT = 2;
    localparam int         RDSEL_BIT       = 0;
    localparam int         COMMIT_BIT      = 0;
    localparam logic [7:0] SETUP_DEFAULT   = 8'h18;
    localparam logic [7:0] CFG_DEFAULT     = 8'h00;
    localparam int         NUM_CFG_DEF     = 4;

    // ------------------------------------------------------------
    // instruction framing
    // ------------------------------------------------------------
    localparam int         INSTR_BITS = 16;
    localparam int         RNW_BIT    = 15;
    localparam int         WCNT_LSB   = 13;
    localparam int         BYTE_BITS  = 8;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] BYTE_LAST  = 4'h7;

    // ------------------------------------------------------------
    // host controller registers (apb, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_CMD  = 8'h00;
    localparam logic [7:0] HOST_TXD  = 8'h04;
    localparam logic [7:0] HOST_RXD  = 8'h08;
    localparam logic [7:0] HOST_STAT = 8'h0C;
    localparam logic [7:0] HOST_MODE = 8'h10;
    localparam int         CMD_RNW_BIT = 13;
    localparam int         CMD_CNT_LSB = 14;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_DONE   = 1;
    localparam int         MODE_LSB    = 0;
    localparam int         MODE_DIR    = 1;
    localparam int         SCLK_HALF_DEF = 2;

endpackage : spcb_pkg

// File: verilog/spcb_link_if.sv
// interface: serial control link between host controller and config bank
`timescale 1ns/1ns
interface spcb_link_if;
    logic sclk;
    logic cs_n;
    logic sdio_host_o;
    logic sdio_host_oe;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdo_o;
    logic sdo_oe;
    logic sdio;
    logic serial_read_out_pin;

    // undriven wires read as pulled high
    assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'h1);
    assign serial_read_out_pin  = sdo_oe ? sdo_o : 1'h1;

    modport host (output sclk, cs_n, sdio_host_o, sdio_host_oe, input sdio, serial_read_out_pin);
    modport dev  (input sclk, cs_n, sdio, output sdio_dev_o, sdio_dev_oe, sdo_o, sdo_oe);
endinterface : spcb_link_if

// File: verilog/spcb_sync.sv
// module: two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module spcb_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spcb_sync_t;

    spcb_sync_t s_reg;
    spcb_sync_t s_next;

    always_comb begin
        s_next = '{s1: d, s2: s_reg.s1};
        if (reset) begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign q = s_reg.s2;
endmodule : spcb_sync

// File: verilog/spcb_dev.sv
// module: configuration bank behind the serial control port, on the link clock
`timescale 1ns/1ns

// Behaviour
// - bidirectional mode reads on data pin, output idle
// - unidirectional mode reads on separate output pin
// - order bit 0: msb first, address decrements
// - order bit 1: lsb first, address increments
// - soft reset restores defaults, never self-clears
// - host writes soft reset back to zero
// - host keeps long instruction framing selected
// - host writes low nibble mirrored from high
// - readback select picks buffer or active copy
module spcb_dev #(
    parameter int NUM_CFG = spcb_pkg::NUM_CFG_DEF
) (
    // reset, synchronous to the link clock
    input  wire logic               reset,
    // link
    spcb_link_if.dev                link,
    // configuration seen by the rest of the chip
    output logic [NUM_CFG-1:0][7:0] cfg_active,
    output logic                    port_dir,
    output logic                    lsb_first,
    output logic                    soft_reset,
    output logic                    readback_active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int IW = $clog2(NUM_CFG);

    typedef enum logic [0:0] {
        D_INSTR,
        D_DATA
    } spcb_dph_t;

    typedef struct packed {
        spcb_dph_t                ph;
        logic [3:0]               cnt;
        logic [15:0]              sh;
        logic [12:0]              addr;
        logic                     rnw;
        logic [7:0]               rbyte;
        logic                     out;
        logic                     oe_io;
        logic                     oe_so;
        logic [7:0]               setup;
        logic                     rdsel;
        logic                     commit;
        logic [NUM_CFG-1:0][7:0]  bufr;
        logic [NUM_CFG-1:0][7:0]  act;
    } spcb_dev_t;

    spcb_dev_t   s_reg;
    spcb_dev_t   s_next;

    logic        lsb;
    logic        dir;
    logic [15:0] sh_in;
    logic [12:0] step;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic        ld;
    logic [7:0]  ld_byte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_cfg(input logic [12:0] a);
        logic [12:0] off;
        off = a - spcb_pkg::REG_CFG_BASE;
        return (a >= spcb_pkg::REG_CFG_BASE) && (off < 13'(NUM_CFG));
    endfunction : in_cfg

    function automatic logic [IW-1:0] cfg_idx(input logic [12:0] a);
        logic [12:0] off;
        off = a - spcb_pkg::REG_CFG_BASE;
        return off[IW-1:0];
    endfunction : cfg_idx

    // unmapped and reserved locations read as zero
    function automatic logic [7:0] rd_reg(input logic [12:0] a, input spcb_dev_t v);
        logic [7:0] r;
        r = 8'h00;
        if (a == spcb_pkg::REG_SETUP) begin
            r = v.setup;
        end else if (a == spcb_pkg::REG_RDSEL) begin
            r[spcb_pkg::RDSEL_BIT] = v.rdsel;
        end else if (a == spcb_pkg::REG_COMMIT) begin
            r[spcb_pkg::COMMIT_BIT] = v.commit;
        end else if (in_cfg(a)) begin
            r = v.rdsel ? v.act[cfg_idx(a)] : v.bufr[cfg_idx(a)];
        end
        return r;
    endfunction : rd_reg

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next  = s_reg;
        wr_en   = 1'h0;
        wr_data = 8'h00;
        ld      = 1'h0;
        ld_byte = 8'h00;
        lsb     = s_reg.setup[spcb_pkg::SETUP_LSB_BIT];
        dir     = s_reg.setup[spcb_pkg::SETUP_DIR_BIT];
        sh_in   = lsb ? {link.sdio, s_reg.sh[15:1]} : {s_reg.sh[14:0], link.sdio};
        step    = lsb ? s_reg.addr + 13'h0001 : s_reg.addr - 13'h0001;

        // pending commit lands one link edge after the write
        if (s_reg.commit) begin
            s_next.act    = s_reg.bufr;
            s_next.commit = 1'h0;
        end

        if (link.cs_n) begin
            s_next.ph    = D_INSTR;
            s_next.cnt   = 4'h0;
            s_next.oe_io = 1'h0;
            s_next.oe_so = 1'h0;
        end else if (s_reg.ph == D_INSTR) begin
            s_next.sh  = sh_in;
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == spcb_pkg::INSTR_LAST) begin
                s_next.ph   = D_DATA;
                s_next.cnt  = 4'h0;
                s_next.addr = sh_in[spcb_pkg::ADDR_W-1:0];
                s_next.rnw  = sh_in[spcb_pkg::RNW_BIT];
                if (sh_in[spcb_pkg::RNW_BIT]) begin
                    ld      = 1'h1;
                    ld_byte = rd_reg(sh_in[spcb_pkg::ADDR_W-1:0], s_reg);
                end
            end
        end else begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.rnw) begin
                s_next.out   = lsb ? s_reg.rbyte[0] : s_reg.rbyte[7];
                s_next.rbyte = lsb ? {1'h0, s_reg.rbyte[7:1]} : {s_reg.rbyte[6:0], 1'h0};
            end else begin
                s_next.sh = sh_in;
            end
            if (s_reg.cnt == spcb_pkg::BYTE_LAST) begin
                s_next.cnt  = 4'h0;
                s_next.addr = step;
                if (s_reg.rnw) begin
                    ld      = 1'h1;
                    ld_byte = rd_reg(step, s_reg);
                end else begin
                    wr_en   = 1'h1;
                    wr_data = lsb ? sh_in[15:8] : sh_in[7:0];
                end
            end
        end

        // first bit of a read byte goes out on the same edge it is fetched
        if (ld) begin
            s_next.out   = lsb ? ld_byte[0] : ld_byte[7];
            s_next.rbyte = lsb ? {1'h0, ld_byte[7:1]} : {ld_byte[6:0], 1'h0};
            s_next.oe_io = ~dir;
            s_next.oe_so = dir;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_en) begin
            if (s_reg.addr == spcb_pkg::REG_SETUP) begin
                s_next.setup = wr_data;
            end else if (s_reg.addr == spcb_pkg::REG_RDSEL) begin
                s_next.rdsel = wr_data[spcb_pkg::RDSEL_BIT];
            end else if (s_reg.addr == spcb_pkg::REG_COMMIT) begin
                if (wr_data[spcb_pkg::COMMIT_BIT]) begin
                    s_next.commit = 1'h1;
                end
            end else if (in_cfg(s_reg.addr)) begin
                s_next.bufr[cfg_idx(s_reg.addr)] = wr_data;
            end
        end

        // held in defaults for as long as the bit stays set
        if (s_next.setup[spcb_pkg::SETUP_SRST_BIT]) begin
            s_next.bufr   = {NUM_CFG{spcb_pkg::CFG_DEFAULT}};
            s_next.act    = {NUM_CFG{spcb_pkg::CFG_DEFAULT}};
            s_next.rdsel  = 1'h0;
            s_next.commit = 1'h0;
        end

        if (reset) begin
            s_next       = '0;
            s_next.ph    = D_INSTR;
            s_next.setup = spcb_pkg::SETUP_DEFAULT;
            s_next.bufr  = {NUM_CFG{spcb_pkg::CFG_DEFAULT}};
            s_next.act   = {NUM_CFG{spcb_pkg::CFG_DEFAULT}};
        end
    end

    // ------------------------------------------------------------
    // registers, all on the link clock
    // ------------------------------------------------------------
    always_ff @(posedge link.sclk) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // same bit feeds both pins; only the enable picks the pin
    assign link.sdio_dev_o  = s_reg.out;
    assign link.sdio_dev_oe = s_reg.oe_io;
    assign link.sdo_o       = s_reg.out;
    assign link.sdo_oe      = s_reg.oe_so;
    assign cfg_active       = s_reg.act;
    assign port_dir         = s_reg.setup[spcb_pkg::SETUP_DIR_BIT];
    assign lsb_first        = s_reg.setup[spcb_pkg::SETUP_LSB_BIT];
    assign soft_reset       = s_reg.setup[spcb_pkg::SETUP_SRST_BIT];
    assign readback_active  = s_reg.rdsel;

endmodule : spcb_dev

// File: verilog/spcb_host.sv
// module: host controller, apb slave driving the serial control link
`timescale 1ns/1ns
module spcb_host #(
    parameter int HALF = spcb_pkg::SCLK_HALF_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    // link
    spcb_link_if.host        link
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam logic [7:0] DIV_M1  = 8'(2 * HALF - 1);
    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
    localparam logic [5:0] IB      = 6'(spcb_pkg::INSTR_BITS);

    typedef enum logic [0:0] {
        H_IDLE,
        H_RUN
    } spcb_hst_t;

    typedef struct packed {
        spcb_hst_t   st;
        logic [7:0]  div;
        logic        sclk;
        logic        cs_n;
        logic        mo;
        logic        oe;
        logic [5:0]  b;
        logic [15:0] instr;
        logic [31:0] tx;
        logic [31:0] txd;
        logic [31:0] rx;
        logic        rnw;
        logic [1:0]  cnt;
        logic [12:0] addr;
        logic        go;
        logic        busy;
        logic        done;
        logic        mlsb;
        logic        mdir;
        logic        pready;
        logic [31:0] prdata;
    } spcb_host_t;

    spcb_host_t  s_reg;
    spcb_host_t  s_next;
    logic [1:0]  pin_s;
    logic        wr;
    logic        rise;
    logic        fall;
    logic [5:0]  d;
    logic [5:0]  total;
    logic [4:0]  tix;
    logic [3:0]  iix;
    logic [15:0] ic;
    logic [31:0] r;

    // pins come from the other side's flops; resync before use
    spcb_sync #(
        .W (2)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({link.sdio, link.serial_read_out_pin}),
        .q     (pin_s)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        wr     = psel & penable & s_reg.pready & pwrite;
        rise   = s_reg.div == DIV_M1;
        fall   = s_reg.div == HALF_M1;
        d      = s_reg.b - IB;
        total  = IB + 6'({s_reg.cnt, 3'h0}) + 6'h08;
        tix    = s_reg.mlsb ? d[4:0] : {d[4:3], ~d[2:0]};
        iix    = s_reg.mlsb ? s_reg.b[3:0] : ~s_reg.b[3:0];
        ic     = {s_reg.rnw, s_reg.cnt, s_reg.addr};
        r      = 32'h0000_0000;

        // apb: zero wait states, pready comes from a flop
        s_next.pready = psel & ~penable;
        if (paddr == spcb_pkg::HOST_CMD) begin
            r = {16'h0000, s_reg.cnt, s_reg.rnw, s_reg.addr};
        end else if (paddr == spcb_pkg::HOST_TXD) begin
            r = s_reg.txd;
        end else if (paddr == spcb_pkg::HOST_RXD) begin
            r = s_reg.rx;
        end else if (paddr == spcb_pkg::HOST_STAT) begin
            r[spcb_pkg::STAT_BUSY] = s_reg.busy;
            r[spcb_pkg::STAT_DONE] = s_reg.done;
        end else if (paddr == spcb_pkg::HOST_MODE) begin
            r[spcb_pkg::MODE_LSB] = s_reg.mlsb;
            r[spcb_pkg::MODE_DIR] = s_reg.mdir;
        end
        if (psel & ~penable) begin
            s_next.prdata = r;
        end

        if (wr && paddr == spcb_pkg::HOST_STAT && pwdata[spcb_pkg::STAT_DONE]) begin
            s_next.done = 1'h0;
        end
        // command, data and mode are locked while a frame is pending
        if (wr && !s_reg.busy) begin
            if (paddr == spcb_pkg::HOST_CMD) begin
                s_next.addr = pwdata[spcb_pkg::ADDR_W-1:0];
                s_next.rnw  = pwdata[spcb_pkg::CMD_RNW_BIT];
                s_next.cnt  = pwdata[spcb_pkg::CMD_CNT_LSB +: 2];
                s_next.tx   = s_reg.txd;
                s_next.go   = 1'h1;
                s_next.busy = 1'h1;
                if (pwdata[spcb_pkg::ADDR_W-1:0] == spcb_pkg::REG_SETUP
                    && !pwdata[spcb_pkg::CMD_RNW_BIT]) begin
                    s_next.tx[spcb_pkg::SETUP_LONG_BIT] = 1'h1;
                    s_next.tx[3:0] = {1'h1, s_reg.txd[5], s_reg.txd[6], s_reg.txd[7]};
                end
            end else if (paddr == spcb_pkg::HOST_TXD) begin
                s_next.txd = pwdata;
            end else if (paddr == spcb_pkg::HOST_MODE) begin
                s_next.mlsb = pwdata[spcb_pkg::MODE_LSB];
                s_next.mdir = pwdata[spcb_pkg::MODE_DIR];
            end
        end

        // ------------------------------------------------------------
        // link clock divider and framing
        // ------------------------------------------------------------
        s_next.div = rise ? 8'h00 : s_reg.div + 8'h01;
        if (rise) begin
            s_next.sclk = 1'h1;
        end else if (fall) begin
            s_next.sclk = 1'h0;
        end

        // sample one clk after a rise: first read bit is clear of our drive and sync
        if (s_reg.div == 8'h00 && s_reg.st == H_RUN) begin
            s_next.b = s_reg.b + 6'h01;
            if (s_reg.rnw && s_reg.b >= IB && s_reg.b < total) begin
                s_next.rx[tix] = s_reg.mdir ? pin_s[0] : pin_s[1];
            end
        end

        // outgoing bits change on the falling edge only
        if (fall) begin
            if (s_reg.st == H_IDLE) begin
                if (s_reg.go) begin
                    s_next.st    = H_RUN;
                    s_next.cs_n  = 1'h0;
                    s_next.b     = 6'h00;
                    s_next.go    = 1'h0;
                    s_next.instr = ic;
                    s_next.mo    = s_reg.mlsb ? ic[0] : ic[15];
                    s_next.oe    = 1'h1;
                end
            end else if (s_reg.b == total) begin
                s_next.st   = H_IDLE;
                s_next.cs_n = 1'h1;
                s_next.oe   = 1'h0;
                if (!s_reg.rnw && s_reg.addr == spcb_pkg::REG_SETUP) begin
                    s_next.mlsb = s_reg.tx[spcb_pkg::SETUP_LSB_BIT];
                    s_next.mdir = s_reg.tx[spcb_pkg::SETUP_DIR_BIT];
                end
                if (!s_reg.rnw && s_reg.addr == spcb_pkg::REG_SETUP
                    && s_reg.tx[spcb_pkg::SETUP_SRST_BIT]) begin
                    s_next.tx[spcb_pkg::SETUP_SRST_BIT]  = 1'h0;
                    s_next.tx[spcb_pkg::SETUP_MSRST_BIT] = 1'h0;
                    s_next.go = 1'h1;
                end else begin
                    s_next.busy = 1'h0;
                    s_next.done = 1'h1;
                end
            end else begin
                s_next.mo = (s_reg.b < IB) ? s_reg.instr[iix] : s_reg.tx[tix];
                s_next.oe = (s_reg.b < IB) | ~s_reg.rnw;
            end
        end

        if (reset) begin
            s_next      = '0;
            s_next.st   = H_IDLE;
            s_next.cs_n = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata            = s_reg.prdata;
    assign pready            = s_reg.pready;
    assign link.sclk         = s_reg.sclk;
    assign link.cs_n         = s_reg.cs_n;
    assign link.sdio_host_o  = s_reg.mo;
    assign link.sdio_host_oe = s_reg.oe;

endmodule : spcb_host

// File: dv/spcb_link_asserts.sv
// checker: frame timing and pin ownership on the config bank link
`timescale 1ns/1ns
module spcb_link_asserts (
    // link clock and device reset
    input logic sclk,
    input logic reset,
    // link pins
    input logic cs_n,
    input logic sdio_dev_oe,
    input logic sdo_oe,
    // device state
    input logic port_dir,
    input logic soft_reset,
    input logic readback_active
);
    // ----------------------------------------
    // rises seen inside the current frame
    // ----------------------------------------
    logic [15:0] cnt_reg;

    always_ff @(posedge sclk) begin
        if (reset || cs_n) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge sclk); endclocking
    default disable iff (reset);

    sequence s_frame_end;
        $rose(cs_n);
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_frame_len: assert property (
        s_frame_end |-> cnt_reg >= 16'h0018 && cnt_reg[2:0] == 3'h0)
        else $error("frame not long instruction plus whole bytes");
    chk_sdo_idle: assert property (!port_dir |-> !sdo_oe)
        else $error("separate output driven in bidirectional mode");
    chk_sdio_quiet: assert property (port_dir |-> !sdio_dev_oe)
        else $error("data pin driven in unidirectional mode");
    chk_one_pin: assert property (!(sdo_oe && sdio_dev_oe))
        else $error("both read pins driven");
    chk_oe_release: assert property (cs_n |=> !sdo_oe && !sdio_dev_oe)
        else $error("read pin held after frame end");
    chk_oe_in_frame: assert property ((sdo_oe || sdio_dev_oe) |-> !$past(cs_n))
        else $error("read pin driven outside a frame");
    chk_oe_late: assert property ((sdo_oe || sdio_dev_oe) |-> cnt_reg >= 16'h0010)
        else $error("read pin driven during instruction");
    chk_srst_stays: assert property ($rose(soft_reset) |=> soft_reset [*8])
        else $error("soft reset cleared itself");
    chk_srst_default: assert property (soft_reset |=> !readback_active)
        else $error("readback select kept under soft reset");
endmodule : spcb_link_asserts

// File: dv/tb_top.sv
// testbench: host and config bank joined over the link, checked against a model
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic            clk = 1'h0;
    logic            reset = 1'h1;
    logic            dev_rst = 1'h1;
    logic            psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, r, rnd = 32'h55A0;
    logic            pready, port_dir, lsb_first, soft_reset, readback_active;
    logic [3:0][7:0] cfg_active;
    logic [15:0]     ins_seen;
    int              bit_n, mismatches, n_compared, cycles, m;
    logic [7:0]      m_setup = 8'h18, m_buf [4] = '{default: 8'h00};
    logic [7:0]      m_act [4] = '{default: 8'h00};
    logic            m_rb = 1'h0;

    spcb_link_if link ();
    spcb_host spcb_host_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .link(link.host));
    spcb_dev #(.NUM_CFG(4)) spcb_dev_i (.reset(dev_rst), .link(link.dev),
        .cfg_active(cfg_active), .port_dir(port_dir), .lsb_first(lsb_first),
        .soft_reset(soft_reset), .readback_active(readback_active));
    spcb_link_asserts spcb_link_asserts_i (.sclk(link.sclk), .reset(dev_rst),
        .cs_n(link.cs_n), .sdio_dev_oe(link.sdio_dev_oe), .sdo_oe(link.sdo_oe),
        .port_dir(port_dir), .soft_reset(soft_reset), .readback_active(readback_active));

    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // instruction bits as seen on the wire, placed by the current order
    always @(posedge link.sclk) begin
        if (link.cs_n) begin
            bit_n = 0;
        end else if (bit_n < 16) begin
            ins_seen[m_setup[6] ? bit_n : 15 - bit_n] = link.sdio;
            bit_n++;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] m_rd(input logic [12:0] a);
        if (a == spcb_pkg::REG_SETUP) return m_setup;
        if (a == spcb_pkg::REG_RDSEL) return {7'h00, m_rb};
        if (a >= spcb_pkg::REG_CFG_BASE && a < spcb_pkg::REG_CFG_BASE + 13'h0004)
            return m_rb ? m_act[a - spcb_pkg::REG_CFG_BASE] : m_buf[a - spcb_pkg::REG_CFG_BASE];
        return 8'h00;
    endfunction : m_rd

    task automatic m_wr(input logic [12:0] a, input logic [7:0] b);
        if (a == spcb_pkg::REG_SETUP) begin
            m_setup = {b[7:5], 1'h1, 1'h1, b[5], b[6], b[7]};
            if (b[5]) begin
                m_buf = '{default: 8'h00};
                m_act = '{default: 8'h00};
                m_rb = 1'h0;
                m_setup = m_setup & 8'hDB;
            end
        end else if (a == spcb_pkg::REG_RDSEL) m_rb = b[0];
        else if (a == spcb_pkg::REG_COMMIT && b[0]) m_act = m_buf;
        else if (a >= spcb_pkg::REG_CFG_BASE && a < spcb_pkg::REG_CFG_BASE + 13'h0004)
            m_buf[a - spcb_pkg::REG_CFG_BASE] = b;
    endtask : m_wr

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic frame(input logic rd, input logic [12:0] a, input int nb,
                         input logic [31:0] d);
        apb(1'h1, spcb_pkg::HOST_TXD, d);
        apb(1'h1, spcb_pkg::HOST_CMD, {16'h0000, 2'(nb - 1), rd, a});
        do begin
            apb(1'h0, spcb_pkg::HOST_STAT, 32'h0);
        end while (r[spcb_pkg::STAT_DONE] !== 1'h1);
        apb(1'h1, spcb_pkg::HOST_STAT, 32'h2);
        chk({16'h0000, ins_seen}, {16'h0000, rd, 2'(nb - 1), a});
        if (rd) apb(1'h0, spcb_pkg::HOST_RXD, 32'h0);
        for (int i = 0; i < nb; i++) begin
            if (rd) chk(r[8*i +: 8], m_rd(m_setup[6] ? a + 13'(i) : a - 13'(i)));
            else m_wr(m_setup[6] ? a + 13'(i) : a - 13'(i), d[8*i +: 8]);
        end
        chk({port_dir, lsb_first, readback_active, soft_reset},
            {m_setup[7], m_setup[6], m_rb, 1'h0});
        chk(cfg_active, {m_act[3], m_act[2], m_act[1], m_act[0]});
        apb(1'h0, spcb_pkg::HOST_MODE, 32'h0);
        chk(r, {30'h0, m_setup[7], m_setup[6]});
    endtask : frame

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // main sequence: every order and direction mode
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge link.sclk);
        dev_rst <= 1'h0;
        repeat (4) @(posedge clk);
        frame(1'h1, spcb_pkg::REG_SETUP, 1, 32'h0);
        frame(1'h1, spcb_pkg::REG_RSVD, 2, 32'h0);
        for (m = 0; m < 4; m++) begin
            frame(1'h0, spcb_pkg::REG_SETUP, 1, {24'h0, m[1:0], 6'h00});
            frame(1'h0, spcb_pkg::REG_CFG_BASE + 13'h0001, 2, rnd);
            rnd = lfsr(rnd);
            frame(1'h1, spcb_pkg::REG_CFG_BASE + 13'h0001, 2, 32'h0);
            frame(1'h0, spcb_pkg::REG_RDSEL, 1, {31'h0, m[0]});
            frame(1'h0, spcb_pkg::REG_COMMIT, 1, 32'h1);
            frame(1'h1, spcb_pkg::REG_COMMIT, 1, 32'h0);
            frame(1'h1, spcb_pkg::REG_CFG_BASE + 13'h0001, 2, 32'h0);
            frame(1'h1, spcb_pkg::REG_SETUP, 1, 32'h0);
        end
        frame(1'h0, spcb_pkg::REG_SETUP, 1, 32'h0);
        frame(1'h0, spcb_pkg::REG_SETUP, 1, 32'h20);
        frame(1'h1, spcb_pkg::REG_CFG_BASE + 13'h0001, 2, 32'h0);
        finish_test();
    end
endmodule : tb_top
